/* File: core/fiber_status_and_prbs_test.v */
// Fiber status, receive error counter and bit sequence test with AXI4-Lite registers.
// How it works
// - Nine events latch flags in the event status register, cleared by reading it.
// - Elastic buffer overflow or underflow latches bit 7 until read.
// - Energy-detect toggle either way latches bit 4 until read.
// - The 16-bit receive error counter saturates at all ones.
// - False carriers and symbol errors both increment the receive error counter.
// - Selector 10 uses x31+x28+1, selector 01 uses x23+x18+1.
// - Selector 00 uses x7+x6+1, selector 11 emits alternating one-zero.
// - With lock gating set, counting starts only after first checker lock.
// - Self-clearing clear bit zeroes the test error count; apart from reset, nothing else does.
// - Separate generator and checker enables; bits 6 and 7 invert polarity.
// - Reading the low half freezes the high half for a coherent read.
// - Test error count is 32 bits in two read-only halves, reset to zero.
// - Each event flag has an enable bit at the same position gating interrupts.
//
// The AXI4-Lite slave port was decided locally.
`default_nettype none
`include "fiber_test_consts.vh"
module fiber_status_and_prbs_test (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        speed_changed,
  input  wire        duplex_changed,
  input  wire        page_received,
  input  wire        aneg_complete,
  input  wire        link_changed,
  input  wire        symbol_error,
  input  wire        false_carrier,
  input  wire        elastic_error,
  input  wire        energy_detect,
  input  wire        rx_bit,
  output reg         tx_bit,
  output reg         irq
);
  // ****************************************************************
  // Registers
  // ****************************************************************
  reg  [15:0] event_reg;
  reg  [15:0] enable_reg;
  reg  [15:0] rx_err_reg;
  reg  [7:0]  ctrl_reg;
  reg  [31:0] test_cnt_reg;
  reg  [15:0] high_hold_reg;
  reg         counting_reg;
  reg         energy_prev_reg;
  reg         energy_seen_reg;
  reg  [1:0]  irq_stat_reg;
  reg  [1:0]  irq_mask_reg;
  reg  [11:0] awaddr_reg;
  reg  [31:0] wdata_reg;
  reg  [3:0]  wstrb_reg;
  reg         aw_have_reg;
  reg         w_have_reg;
  reg  [15:0] event_next;
  reg  [15:0] rd_val;
  reg         rd_ok;
  wire        gen_tx;
  wire        mismatch;
  wire        locked;
  wire        wr_go;
  wire        rd_go;
  wire [7:0]  wr_idx;
  wire [7:0]  rd_idx;
  wire        wr_ok;
  wire        clear_pulse;
  wire        count_en;
  wire [15:0] enable_mask;
  wire [1:0]  rx_err_inc;
  wire [16:0] rx_err_sum;

  // Word index from a byte address; bits below the word are ignored.
  function [7:0] word_idx;
    input [11:0] a;
    begin
      word_idx = a[9:2];
    end
  endfunction

  // ****************************************************************
  // Bus slave: write and read channels
  // ****************************************************************
  // Address and data may arrive in either order; the response waits for both,
  // and neither channel is accepted again until the response has been taken.
  assign wr_go  = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign wr_idx = word_idx(awaddr_reg);
  assign wr_ok  = (wr_idx == `IDX_EVENT_ENABLE) || (wr_idx == `IDX_TEST_CONTROL) ||
                  (wr_idx == `IDX_IRQ_STATUS) || (wr_idx == `IDX_IRQ_MASK);
  assign rd_go  = s_axi_arvalid && s_axi_arready;
  assign rd_idx = word_idx(s_axi_araddr);

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      awaddr_reg    <= 12'h000;
      wdata_reg     <= 32'h00000000;
      wstrb_reg     <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_reg    <= s_axi_awaddr;
        aw_have_reg   <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
        w_have_reg   <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always @* begin
    rd_ok  = 1'b1;
    rd_val = `RESET_ZERO16;
    case (rd_idx)
      `IDX_EVENT_STATUS:  rd_val = event_reg;
      `IDX_EVENT_ENABLE:  rd_val = enable_reg;
      `IDX_RX_ERR_COUNT:  rd_val = rx_err_reg;
      `IDX_TEST_CONTROL:  rd_val = {8'h00, ctrl_reg};
      `IDX_TEST_ERR_LOW:  rd_val = test_cnt_reg[15:0];
      `IDX_TEST_ERR_HIGH: rd_val = high_hold_reg;
      `IDX_IRQ_STATUS:    rd_val = {14'h0000, irq_stat_reg};
      `IDX_IRQ_MASK:      rd_val = {14'h0000, irq_mask_reg};
      default:            rd_ok = 1'b0;
    endcase
  end

  // Side effects of a read (flag clear, counter clear, snapshot) act at the
  // address edge, so they happen once per read whatever the response delay.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'h0;
    end else if (rd_go) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {16'h0000, rd_val};
      s_axi_rresp   <= rd_ok ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************************************
  // Event status and receive error counter
  // ****************************************************************
  // A read clears the flags it returned; an event in the same cycle survives.
  always @* begin
    event_next = (rd_go && rd_idx == `IDX_EVENT_STATUS) ? `RESET_ZERO16 : event_reg;
    event_next[`EV_SPEED]         = event_next[`EV_SPEED] | speed_changed;
    event_next[`EV_DUPLEX]        = event_next[`EV_DUPLEX] | duplex_changed;
    event_next[`EV_PAGE]          = event_next[`EV_PAGE] | page_received;
    event_next[`EV_ANEG]          = event_next[`EV_ANEG] | aneg_complete;
    event_next[`EV_LINK]          = event_next[`EV_LINK] | link_changed;
    event_next[`EV_SYMBOL]        = event_next[`EV_SYMBOL] | symbol_error;
    event_next[`EV_FALSE_CARRIER] = event_next[`EV_FALSE_CARRIER] | false_carrier;
    event_next[`EV_FIFO]          = event_next[`EV_FIFO] | elastic_error;
    event_next[`EV_ENERGY]        = event_next[`EV_ENERGY] |
                                    (energy_seen_reg && (energy_detect != energy_prev_reg));
  end

  // Both error kinds may fire in one cycle, and each of them counts.
  assign enable_mask = `EV_VALID_MASK;
  assign rx_err_inc  = {1'b0, symbol_error} + {1'b0, false_carrier};
  assign rx_err_sum  = {1'b0, rx_err_reg} + {15'h0000, rx_err_inc};

  always @(posedge aclk) begin
    if (!aresetn) begin
      event_reg       <= `RESET_ZERO16;
      enable_reg      <= `RESET_ZERO16;
      rx_err_reg      <= `RESET_ZERO16;
      energy_prev_reg <= 1'b0;
      energy_seen_reg <= 1'b0;
    end else begin
      event_reg       <= event_next;
      energy_prev_reg <= energy_detect;
      energy_seen_reg <= 1'b1;
      if (wr_go && wr_idx == `IDX_EVENT_ENABLE && wstrb_reg[0])
        enable_reg[7:0] <= wdata_reg[7:0] & enable_mask[7:0];
      if (wr_go && wr_idx == `IDX_EVENT_ENABLE && wstrb_reg[1])
        enable_reg[15:8] <= wdata_reg[15:8] & enable_mask[15:8];
      // An error in the read cycle is counted after the clear, not lost.
      if (rd_go && rd_idx == `IDX_RX_ERR_COUNT)
        rx_err_reg <= {14'h0000, rx_err_inc};
      else if (rx_err_sum[16])
        rx_err_reg <= `COUNT_MAX16;
      else
        rx_err_reg <= rx_err_sum[15:0];
    end
  end

  // ****************************************************************
  // Test control and error count
  // ****************************************************************
  // With lock gating the count waits for the first lock and then keeps running,
  // even if the checker later loses lock; a relock is not needed to resume.
  assign clear_pulse = ctrl_reg[`TC_CLEAR];
  assign count_en    = ctrl_reg[`TC_CHK_EN] && (!ctrl_reg[`TC_LOCK_GATE] || counting_reg);

  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg      <= 8'h00;
      test_cnt_reg  <= 32'h00000000;
      high_hold_reg <= `RESET_ZERO16;
      counting_reg  <= 1'b0;
    end else begin
      if (wr_go && wr_idx == `IDX_TEST_CONTROL && wstrb_reg[0])
        ctrl_reg <= wdata_reg[7:0];
      else
        ctrl_reg[`TC_CLEAR] <= 1'b0;
      if (!ctrl_reg[`TC_CHK_EN])
        counting_reg <= 1'b0;
      else if (locked)
        counting_reg <= 1'b1;
      if (clear_pulse)
        test_cnt_reg <= 32'h00000000;
      else if (count_en && mismatch && test_cnt_reg != `COUNT_MAX32)
        test_cnt_reg <= test_cnt_reg + 32'h00000001;
      // The upper half is served from a snapshot taken at each lower-half read,
      // so reading low then high gives a coherent count while the checker runs.
      if (clear_pulse)
        high_hold_reg <= `RESET_ZERO16;
      else if (rd_go && rd_idx == `IDX_TEST_ERR_LOW)
        high_hold_reg <= test_cnt_reg[31:16];
    end
  end

  seq_engine engine (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .gen_en   (ctrl_reg[`TC_GEN_EN]),
    .chk_en   (ctrl_reg[`TC_CHK_EN]),
    .pattern  (ctrl_reg[`TC_PAT_LO+1:`TC_PAT_LO]),
    .gen_inv  (ctrl_reg[`TC_GEN_INV]),
    .chk_inv  (ctrl_reg[`TC_CHK_INV]),
    .rx_bit   (rx_bit),
    .tx_bit   (gen_tx),
    .mismatch (mismatch),
    .locked   (locked)
  );

  // ****************************************************************
  // Interrupt
  // ****************************************************************
  // Sticky bits clear on writing one; a new event in that cycle wins.
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_reg <= 2'h0;
      irq_mask_reg <= 2'h0;
      irq          <= 1'b0;
      tx_bit       <= 1'b0;
    end else begin
      tx_bit <= gen_tx;
      if (wr_go && wr_idx == `IDX_IRQ_MASK && wstrb_reg[0])
        irq_mask_reg <= wdata_reg[1:0];
      irq_stat_reg[`IRQ_EVENT] <= ((|(event_reg & enable_reg)) |
        (irq_stat_reg[`IRQ_EVENT] & ~(wr_go && wr_idx == `IDX_IRQ_STATUS &&
        wstrb_reg[0] && wdata_reg[`IRQ_EVENT])));
      irq_stat_reg[`IRQ_TEST_ERR] <= (count_en & mismatch) |
        (irq_stat_reg[`IRQ_TEST_ERR] & ~(wr_go && wr_idx == `IDX_IRQ_STATUS &&
        wstrb_reg[0] && wdata_reg[`IRQ_TEST_ERR]));
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end
endmodule
`default_nettype wire

/* File: core/fiber_test_consts.vh */
// Constants for the fiber status and bit sequence test block.
`ifndef FIBER_TEST_CONSTS_VH
`define FIBER_TEST_CONSTS_VH
// Register indices; the byte address is four times the index.
`define IDX_EVENT_STATUS   8'h13
`define IDX_RX_ERR_COUNT   8'h15
`define IDX_TEST_CONTROL   8'h17
`define IDX_TEST_ERR_LOW   8'h18
`define IDX_TEST_ERR_HIGH  8'h19
`define IDX_EVENT_ENABLE   8'h12
`define IDX_IRQ_STATUS     8'h30
`define IDX_IRQ_MASK       8'h31
// Event status bit positions.
`define EV_SPEED           14
`define EV_DUPLEX          13
`define EV_PAGE            12
`define EV_ANEG            11
`define EV_LINK            10
`define EV_SYMBOL          9
`define EV_FALSE_CARRIER   8
`define EV_FIFO            7
`define EV_ENERGY          4
`define EV_VALID_MASK      16'h7f90
// Test control bit positions.
`define TC_GEN_EN          0
`define TC_CHK_EN          1
`define TC_PAT_LO          2
`define TC_CLEAR           4
`define TC_LOCK_GATE       5
`define TC_GEN_INV         6
`define TC_CHK_INV         7
// Pattern selector codes.
`define PAT_SEQ7           2'h0
`define PAT_SEQ23          2'h1
`define PAT_SEQ31          2'h2
`define PAT_ALT            2'h3
// Reset values and limits.
`define RESET_ZERO16       16'h0000
`define COUNT_MAX16        16'hffff
`define COUNT_MAX32        32'hffffffff
// Irq register bits: 0 event summary, 1 test error.
`define IRQ_EVENT          0
`define IRQ_TEST_ERR       1
// Checker declares lock after this many matching bits in a row.
`define LOCK_MATCHES       6'd32
`endif

/* File: core/seq_engine.v */
// Bit sequence generator and checker engine.
`default_nettype none
`include "fiber_test_consts.vh"
module seq_engine (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        gen_en,
  input  wire        chk_en,
  input  wire [1:0]  pattern,
  input  wire        gen_inv,
  input  wire        chk_inv,
  input  wire        rx_bit,
  output reg         tx_bit,
  output reg         mismatch,
  output reg         locked
);
  reg  [30:0] gen_reg;
  reg  [30:0] chk_reg;
  reg         alt_reg;
  reg  [5:0]  match_reg;
  wire        rx_in;
  wire        fb_gen;
  wire        fb_chk;

  // Feedback of the selected polynomial; the new bit is shifted into bit 0.
  function feedback;
    input [30:0] s;
    input [1:0]  p;
    begin
      case (p)
        `PAT_SEQ7:  feedback = s[6] ^ s[5];
        `PAT_SEQ23: feedback = s[22] ^ s[17];
        `PAT_SEQ31: feedback = s[30] ^ s[27];
        default:    feedback = 1'b0;
      endcase
    end
  endfunction

  assign fb_gen = feedback(gen_reg, pattern);
  assign fb_chk = feedback(chk_reg, pattern);
  assign rx_in  = rx_bit ^ chk_inv;

  always @(posedge aclk) begin
    if (!aresetn || !gen_en) begin
      gen_reg <= 31'h7fffffff;
      alt_reg <= 1'b0;
      tx_bit  <= 1'b0;
    end else begin
      // Holding the register in the alternating mode keeps it from filling
      // with zeros, a state from which no polynomial could restart.
      if (pattern != `PAT_ALT)
        gen_reg <= {gen_reg[29:0], fb_gen};
      alt_reg <= ~alt_reg;
      if (pattern == `PAT_ALT)
        tx_bit <= ~alt_reg ^ gen_inv;
      else
        tx_bit <= fb_gen ^ gen_inv;
    end
  end

  // The checker is self-synchronising: it shifts in received bits and
  // compares each with the prediction from the previous ones.
  always @(posedge aclk) begin
    if (!aresetn || !chk_en) begin
      chk_reg   <= 31'h00000000;
      match_reg <= 6'd0;
      locked    <= 1'b0;
      mismatch  <= 1'b0;
    end else begin
      chk_reg  <= {chk_reg[29:0], rx_in};
      if (pattern == `PAT_ALT)
        mismatch <= (rx_in == chk_reg[0]);
      else
        mismatch <= (rx_in != fb_chk);
      if ((pattern == `PAT_ALT) ? (rx_in == chk_reg[0]) : (rx_in != fb_chk))
        match_reg <= 6'd0;
      else if (match_reg != `LOCK_MATCHES)
        match_reg <= match_reg + 6'd1;
      if (match_reg == `LOCK_MATCHES)
        locked <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: tb/fiber_test_props.sv */
// Concurrent checks on the top-level ports of the fiber test block.
`default_nettype none
module fiber_test_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        tx_bit,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence r_done;
    s_axi_rvalid && s_axi_rready;
  endsequence
  ar_answer_a: assert property (ar_take |=> s_axi_rvalid)
    else $error("read answer late");
  wr_answer_a: assert property (wr_take |-> ##[1:3] s_axi_bvalid)
    else $error("write answer late");
  aw_busy_a: assert property (wr_take |=> !s_axi_awready && !s_axi_wready)
    else $error("write accepted twice");
  rd_free_a: assert property (r_done |-> ##[1:2] s_axi_arready)
    else $error("read port stuck");
  r_once_a: assert property (r_done |=> !s_axi_rvalid)
    else $error("read answered twice");
  b_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answered twice");
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  rd_resp_a: assert property (s_axi_rvalid |-> s_axi_rresp != 2'h1 && s_axi_rresp != 2'h3)
    else $error("bad read response");
  reset_quiet_a: assert property ($rose(aresetn) |-> !tx_bit && !irq)
    else $error("outputs active after reset");
endmodule
bind fiber_status_and_prbs_test fiber_test_props u_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .tx_bit(tx_bit), .irq(irq)
);
`default_nettype wire

/* File: tb/fiber_partner.sv */
// Loopback model of the far fiber end with commanded bit errors.
`default_nettype none
module fiber_partner (
  input  wire logic aclk,
  input  wire logic tx_bit,
  input  wire logic flip,
  output var  logic rx_bit
);
  timeunit 1ns;
  timeprecision 1ns;
  // The line returns each sent bit one clock later; a flip corrupts exactly that one bit.
  always @(posedge aclk) begin
    rx_bit <= tx_bit ^ flip;
  end
endmodule
`default_nettype wire

/* File: tb/fiber_status_and_prbs_test_tb.sv */
// Self-checking testbench for the fiber status and bit sequence test block.
`default_nettype none
`include "fiber_test_consts.vh"
module fiber_status_and_prbs_test_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] i; logic [15:0] d; logic [1:0] r;} row_t;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, energy, flip;
  logic        awready, wready, bvalid, arready, rvalid, tx_bit, rx_bit, irq, e;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, got, h;
  logic [1:0]  bresp, rresp, resp;
  logic [7:0]  ev;
  logic [15:0] c;
  int          error_cnt, checks_done;
  row_t rows[9] = '{'{8'h12, 0, 0}, '{8'h13, 0, 0}, '{8'h15, 0, 0}, '{8'h17, 0, 0},
    '{8'h18, 0, 0}, '{8'h19, 0, 0}, '{8'h30, 0, 0}, '{8'h31, 0, 0}, '{8'h20, 0, 2'h2}};
  fiber_status_and_prbs_test u_fiber_status_and_prbs_test (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .speed_changed(ev[7]), .duplex_changed(ev[6]), .page_received(ev[5]),
    .aneg_complete(ev[4]), .link_changed(ev[3]), .symbol_error(ev[2]),
    .false_carrier(ev[1]), .elastic_error(ev[0]), .energy_detect(energy),
    .rx_bit(rx_bit), .tx_bit(tx_bit), .irq(irq));
  fiber_partner u_fiber_partner (.aclk(aclk), .tx_bit(tx_bit), .flip(flip), .rx_bit(rx_bit));
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    h <= {h[30:0], tx_bit};
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic results;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Called just after an edge; bready and rready stay high for the whole run.
  task automatic wr(input logic [7:0] i, input logic [15:0] d, output logic [1:0] r);
    logic a, w;
    a = 1'b0;
    w = 1'b0;
    awaddr <= {2'h0, i, 2'h0};
    wdata <= {16'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(a && w)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        a = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    r = bresp;
  endtask
  task automatic rd(input logic [7:0] i, output logic [31:0] d, output logic [1:0] r);
    araddr <= {2'h0, i, 2'h0};
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
  endtask
  initial begin
    cyc(80000);
    error_cnt++;
    results();
  end
  initial begin
    {aresetn, awvalid, wvalid, arvalid, energy, flip, ev, awaddr, araddr, wdata} = '0;
    bready = 1'b1;
    rready = 1'b1;
    cyc(12);
    aresetn <= 1'b1;
    foreach (rows[k]) begin
      rd(rows[k].i, got, resp);
      chk(got, {16'h0, rows[k].d});
      chk({30'h0, resp}, {30'h0, rows[k].r});
    end
    wr(`IDX_TEST_ERR_LOW, 16'h0001, resp);
    chk({30'h0, resp}, 32'h2);
    ev <= 8'hff;
    energy <= 1'b1;
    @(posedge aclk);
    ev <= 8'h00;
    @(posedge aclk);
    rd(`IDX_EVENT_STATUS, got, resp);
    chk(got, 32'h7f90);
    rd(`IDX_EVENT_STATUS, got, resp);
    chk(got, 32'h0);
    // One cycle with a symbol error and a false carrier holds two errors.
    rd(`IDX_RX_ERR_COUNT, got, resp);
    chk(got, 32'h2);
    rd(`IDX_RX_ERR_COUNT, got, resp);
    chk(got, 32'h0);
    wr(`IDX_EVENT_ENABLE, 16'h0100, resp);
    ev <= 8'h02;
    @(posedge aclk);
    ev <= 8'h00;
    cyc(4);
    chk({31'h0, irq}, 32'h0);
    wr(`IDX_IRQ_MASK, 16'h0001, resp);
    cyc(4);
    chk({31'h0, irq}, 32'h1);
    rd(`IDX_EVENT_STATUS, got, resp);
    chk(got, 32'h0100);
    wr(`IDX_IRQ_STATUS, 16'h0001, resp);
    cyc(4);
    chk({31'h0, irq}, 32'h0);
    // Each generated bit must follow the recurrence of the selected polynomial, or invert the previous bit with selector 11.
    for (int p = 0; p < 4; p++) begin
      wr(`IDX_TEST_CONTROL, {12'h0, p[1:0], 2'b01}, resp);
      cyc(40);
      repeat (40) begin
        @(posedge aclk);
        e = p == 0 ? h[6] ^ h[5] : p == 1 ? h[22] ^ h[17] : p == 2 ? h[30] ^ h[27] : ~h[0];
        chk({31'h0, tx_bit}, {31'h0, e});
      end
    end
    // One line error is seen three times by a polynomial checker (the bit and each
    // tap) and twice by the alternating checker (the bit and the one after it).
    for (int p = 0; p < 4; p++) begin
      c = {8'h0, p == 1 ? 2'b11 : 2'b00, 2'b10, p[1:0], 2'b11};
      wr(`IDX_TEST_CONTROL, c, resp);
      cyc(100);
      wr(`IDX_TEST_CONTROL, c | 16'h0010, resp);
      cyc(5);
      flip <= 1'b1;
      @(posedge aclk);
      flip <= 1'b0;
      cyc(80);
      rd(`IDX_TEST_ERR_LOW, got, resp);
      chk(got, p == 3 ? 32'h2 : 32'h3);
      rd(`IDX_TEST_ERR_HIGH, got, resp);
      chk(got, 32'h0);
    end
    aresetn <= 1'b0;
    cyc(2);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`IDX_TEST_ERR_LOW, got, resp);
    chk(got, 32'h0);
    rd(`IDX_TEST_CONTROL, got, resp);
    chk(got, 32'h0);
    wr(`IDX_TEST_CONTROL, 16'h0063, resp);
    cyc(100);
    rd(`IDX_TEST_ERR_LOW, got, resp);
    chk(got, 32'h0);
    wr(`IDX_TEST_CONTROL, 16'h0053, resp);
    cyc(100);
    rd(`IDX_TEST_ERR_LOW, got, resp);
    chk({31'h0, got == 32'h0}, 32'h0);
    wr(`IDX_TEST_CONTROL, 16'h0050, resp);
    cyc(3);
    rd(`IDX_TEST_ERR_LOW, got, resp);
    chk(got, 32'h0);
    rd(`IDX_TEST_CONTROL, got, resp);
    chk(got, 32'h0040);
    // Every bit mismatches, so the count carries into its upper half meanwhile.
    wr(`IDX_TEST_CONTROL, 16'h0043, resp);
    ev <= 8'h02;
    cyc(65600);
    ev <= 8'h00;
    wr(`IDX_TEST_CONTROL, 16'h0040, resp);
    rd(`IDX_TEST_ERR_HIGH, got, resp);
    chk(got, 32'h0);
    rd(`IDX_TEST_ERR_LOW, got, resp);
    rd(`IDX_TEST_ERR_HIGH, got, resp);
    chk(got, 32'h1);
    rd(`IDX_RX_ERR_COUNT, got, resp);
    chk(got, 32'hffff);
    wr(`IDX_IRQ_MASK, 16'h0002, resp);
    cyc(3);
    chk({31'h0, irq}, 32'h1);
    wr(`IDX_IRQ_STATUS, 16'h0002, resp);
    cyc(3);
    chk({31'h0, irq}, 32'h0);
    results();
  end
endmodule
`default_nettype wire
